// ### reload_timer_pair_defines.vh
// Purpose: constants for the dual reload timer with remote transmit
// Assumes: 16-bit register port, word-wide offsets, 125 MHz system clock
// Notes: offsets count in words; byte lanes follow the port's byte enables
`ifndef RELOAD_TIMER_PAIR_DEFINES_VH
`define RELOAD_TIMER_PAIR_DEFINES_VH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define OFS_CONTROL 3'h0
`define OFS_MODE 3'h1
`define OFS_FLAGS 3'h2
`define OFS_LOWER 3'h3
`define OFS_UPPER 3'h4
`define OFS_MSTOP 3'h5

// ------------------------------------------------------------------
// control register fields
// ------------------------------------------------------------------
`define CTL_EXN_BIT 3
`define CTL_UIE_BIT 2
`define CTL_LIE_BIT 1
`define CTL_PS22_BIT 0
`define CTL_RESET 8'h08

// ------------------------------------------------------------------
// mode register fields
// ------------------------------------------------------------------
`define MODE_ST_BIT 7
`define MODE_REMOTE_BIT 6
`define MODE_CASC_BIT 5
`define MODE_TGL_BIT 4
`define MODE_PS21_BIT 3
`define MODE_PS20_BIT 2
`define MODE_PS11_BIT 1
`define MODE_PS10_BIT 0
`define MODE_RESET 8'h00

// ------------------------------------------------------------------
// flag register fields
// ------------------------------------------------------------------
`define FLG_UPPER_BIT 7
`define FLG_LOWER_BIT 6
`define FLG_RESERVED 8'h3f

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define CNT8_RESET 8'hff
`define CNT16_RESET 16'h00ff
`define MSTOP_RESET 1'b1

// ------------------------------------------------------------------
// prescaler taps
// ------------------------------------------------------------------
`define PRE_WIDTH 11
`define TAP_DIV2 0
`define TAP_DIV64 5
`define TAP_DIV128 6
`define TAP_DIV1024 9
`define TAP_DIV2048 10

`endif

// ### reload_timer_pair.v
// Purpose: two chained reload down-counters with tone and remote transmit output
// Assumes: 16-bit register port with byte enables, edge pins asynchronous
// Notes: counters load and reload; flags clear by writing 0 after reading 1
//
// Summary of operation
// - module stop bit, reset to 1, halts both timers; 0 lets them run
// - lower timer counts divided clock or pin A edges, reloading still works
// - writing lower reload value also loads lower counter at once
// - lower underflow reloads lower counter and raises lower request
// - tone output inverts on every lower underflow
// - cascaded 16-bit uses upper byte and lower byte, word access only
// - 16-bit write loads whole counter, whole underflow reloads whole value
// - expansion select 0 makes upper 16 bits, chained gives 24-bit counter
// - lower request and tone stay active during cascaded operation
// - upper counts divided clock, pin B edges or lower underflows
// - upper reload write loads counter; underflow reloads and raises request
// - remote mode: lower makes carrier, upper times burst and space
// - setting start bit loads both counters as transmission begins
// - during transmission upper reload write waits for next underflow
// - low-power entry clears the start bit
// - start bit takes effect on the upper timer input clock
// - expansion word read swaps upper counter bytes on the bus
// - expansion word write swaps bytes into upper reload value
// - underflow sets flag; write 0 after reading 1 clears it
// - each request reaches processor only when its enable is 1
// - 8-bit timer underflows every 1 to 256 input clocks
`timescale 1ns/1ps
`include "reload_timer_pair_defines.vh"

module reload_timer_pair (
    input wire sys_clk_i,
    input wire resetn_i,
    input wire [2:0] addr_i,
    input wire [15:0] wdata_i,
    input wire [1:0] byte_en_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    input wire ext_edge_pin_a_i,
    input wire ext_edge_pin_b_i,
    input wire pin_a_falling_i,
    input wire pin_b_falling_i,
    input wire low_power_i,
    output reg lower_irq_o,
    output reg upper_irq_o,
    output reg tone_o,
    output reg remote_tx_o
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_n;

    // async assert, two-flop release
    // the rest of the design sees only the released copy
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    reg [7:0] control_reg;
    reg [7:0] mode_reg;
    reg lower_underflow_flag_reg;
    reg upper_underflow_flag_reg;
    reg lower_flag_seen_reg;
    reg upper_flag_seen_reg;
    reg module_stop_reg;
    reg [7:0] lower_reload_value_reg;
    reg [15:0] upper_reload_value_reg;
    reg [7:0] lower_down_counter_reg;
    reg [15:0] upper_down_counter_reg;
    reg burst_space_toggle_reg;
    reg tx_active_reg;
    reg [`PRE_WIDTH-1:0] pre_reg;
    reg [`PRE_WIDTH-1:0] pre_prev_reg;
    reg [2:0] pin_a_sync_reg;
    reg [2:0] pin_b_sync_reg;
    reg [2:0] sync_fill_reg;

    wire expansion_select = control_reg[`CTL_EXN_BIT];
    wire cascaded = mode_reg[`MODE_CASC_BIT];
    wire remote_mode = mode_reg[`MODE_REMOTE_BIT];
    wire transmit_start_bit = mode_reg[`MODE_ST_BIT];
    wire run = ~module_stop_reg;

    // rising edge of one prescaler tap, one cycle wide
    function tap_pulse;
        input [`PRE_WIDTH-1:0] now;
        input [`PRE_WIDTH-1:0] prev;
        input integer tap;
        begin
            tap_pulse = now[tap] & ~prev[tap];
        end
    endfunction

    // chosen pin edge from the last two settled samples
    function pin_edge;
        input [2:0] s;
        input falling;
        begin
            pin_edge = falling ? (s[2] & ~s[1]) : (~s[2] & s[1]);
        end
    endfunction

    // ------------------------------------------------------------------
    // prescaler and pin synchronisers
    // ------------------------------------------------------------------
    // one divider feeds all rates, so taps stay in phase
    // prescaler frozen in stop so the divider draws no toggling there
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= {`PRE_WIDTH{1'b0}};
            pre_prev_reg <= {`PRE_WIDTH{1'b0}};
            pin_a_sync_reg <= 3'h0;
            pin_b_sync_reg <= 3'h0;
            sync_fill_reg <= 3'h0;
        end else begin
            if (run) begin
                pre_reg <= pre_reg + {{(`PRE_WIDTH-1){1'b0}}, 1'b1};
            end
            pre_prev_reg <= pre_reg;
            // bit 0 is the meta flop; only bit 1 reads it
            pin_a_sync_reg <= {pin_a_sync_reg[1:0], ext_edge_pin_a_i};
            pin_b_sync_reg <= {pin_b_sync_reg[1:0], ext_edge_pin_b_i};
            // edges count only once the pin pipe holds real samples,
            // else an idle-high pin fakes a rising edge after reset
            sync_fill_reg <= {sync_fill_reg[1:0], 1'b1};
        end
    end

    // ------------------------------------------------------------------
    // count enables
    // ------------------------------------------------------------------
    reg lower_tick;
    reg upper_src_tick;
    wire lower_uf;
    wire lower_uf8;
    wire upper_uf;
    wire upper_tick;
    wire upper_at_zero;

    // ticks are one cycle wide: one step per input clock
    // lower clock: 3 divided rates or pin A edges
    always @* begin
        case (mode_reg[1:0])
            2'h0: lower_tick = tap_pulse(pre_reg, pre_prev_reg, `TAP_DIV2048);
            2'h1: lower_tick = tap_pulse(pre_reg, pre_prev_reg, `TAP_DIV128);
            2'h2: lower_tick = tap_pulse(pre_reg, pre_prev_reg, `TAP_DIV2);
            default: lower_tick = sync_fill_reg[2] & pin_edge(pin_a_sync_reg, pin_a_falling_i);
        endcase
    end

    // upper clock: divided rates, lower underflow or pin B edges
    always @* begin
        case ({mode_reg[`MODE_PS21_BIT], mode_reg[`MODE_PS20_BIT]})
            2'h0: upper_src_tick = control_reg[`CTL_PS22_BIT] ?
                tap_pulse(pre_reg, pre_prev_reg, `TAP_DIV128) :
                tap_pulse(pre_reg, pre_prev_reg, `TAP_DIV1024);
            2'h1: upper_src_tick = control_reg[`CTL_PS22_BIT] ?
                tap_pulse(pre_reg, pre_prev_reg, `TAP_DIV64) :
                tap_pulse(pre_reg, pre_prev_reg, `TAP_DIV1024);
            2'h2: upper_src_tick = lower_uf8;
            default: upper_src_tick = sync_fill_reg[2] &
                pin_edge(pin_b_sync_reg, pin_b_falling_i);
        endcase
    end

    // cascade: upper steps on lower wrap, only whole-counter zero underflows
    assign upper_at_zero = expansion_select ? (upper_down_counter_reg[7:0] == 8'h00) :
        (upper_down_counter_reg == 16'h0000);
    assign lower_uf8 = run & lower_tick & (lower_down_counter_reg == 8'h00);
    assign upper_tick = run & (cascaded ? lower_uf8 : upper_src_tick);
    assign upper_uf = upper_tick & upper_at_zero;
    // cascade chains the upper low byte, or the whole upper counter at expansion select 0
    // in cascade the lower reloads only with the whole counter
    assign lower_uf = cascaded ? (lower_uf8 & upper_at_zero) : lower_uf8;

    // ------------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------------
    wire wr_ctl = wr_i & (addr_i == `OFS_CONTROL) & byte_en_i[0];
    wire wr_mode = wr_i & (addr_i == `OFS_MODE) & byte_en_i[0];
    wire wr_flags = wr_i & (addr_i == `OFS_FLAGS) & byte_en_i[0];
    wire wr_mstop = wr_i & (addr_i == `OFS_MSTOP) & byte_en_i[0];
    wire wr_lower = wr_i & (addr_i == `OFS_LOWER);
    wire wr_upper = wr_i & (addr_i == `OFS_UPPER);
    wire word_wr = byte_en_i == 2'h3;
    // cascaded reload pair only takes word writes
    wire casc_wr = cascaded & wr_lower & word_wr;
    wire lower_load = cascaded ? casc_wr : (wr_lower & byte_en_i[0]);
    // refused writes leave value and counter untouched
    // expansion on (select 0): 16-bit upper value by word only, bytes swapped
    wire upper_wr_ok = expansion_select ? (wr_upper & byte_en_i[0]) : (wr_upper & word_wr);
    wire [15:0] upper_wdata = expansion_select ? {8'h00, wdata_i[7:0]} :
        {wdata_i[7:0], wdata_i[15:8]};
    // reload value is held off from the counter while sending
    wire upper_direct = ~tx_active_reg;
    wire st_set_req = wr_mode & wdata_i[`MODE_ST_BIT];

    // ------------------------------------------------------------------
    // control, mode, stop and flag registers
    // ------------------------------------------------------------------
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            control_reg <= `CTL_RESET;
            mode_reg <= `MODE_RESET;
            module_stop_reg <= `MSTOP_RESET;
            lower_underflow_flag_reg <= 1'b0;
            upper_underflow_flag_reg <= 1'b0;
            lower_flag_seen_reg <= 1'b0;
            upper_flag_seen_reg <= 1'b0;
        end else begin
            if (wr_ctl) begin
                control_reg <= {4'h0, wdata_i[3:0]};
            end
            // start bit and toggle are kept by hardware below
            if (wr_mode) begin
                mode_reg[6:5] <= wdata_i[6:5];
                mode_reg[3:0] <= wdata_i[3:0];
            end
            // start bit moves at once; sending starts on the upper clock
            // a set needs remote mode from an earlier write
            if (low_power_i) begin
                mode_reg[`MODE_ST_BIT] <= 1'b0;
            end else if (wr_mode & ~wdata_i[`MODE_ST_BIT]) begin
                mode_reg[`MODE_ST_BIT] <= 1'b0;
            end else if (st_set_req & remote_mode) begin
                mode_reg[`MODE_ST_BIT] <= 1'b1;
            end
            mode_reg[`MODE_TGL_BIT] <= burst_space_toggle_reg;
            if (wr_mstop) begin
                module_stop_reg <= wdata_i[5];
            end
            // remember a read of 1 so a later write of 0 may clear
            // a read of 0 does not arm the clear
            if (rd_i & (addr_i == `OFS_FLAGS)) begin
                lower_flag_seen_reg <= lower_underflow_flag_reg;
                upper_flag_seen_reg <= upper_underflow_flag_reg;
            end
            // set wins over a clear in the same cycle
            if (lower_uf) begin
                lower_underflow_flag_reg <= 1'b1;
            end else if (wr_flags & ~wdata_i[`FLG_LOWER_BIT] & lower_flag_seen_reg) begin
                lower_underflow_flag_reg <= 1'b0;
                lower_flag_seen_reg <= 1'b0;
            end
            if (upper_uf) begin
                upper_underflow_flag_reg <= 1'b1;
            end else if (wr_flags & ~wdata_i[`FLG_UPPER_BIT] & upper_flag_seen_reg) begin
                upper_underflow_flag_reg <= 1'b0;
                upper_flag_seen_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // counters, reload values and transmit state
    // ------------------------------------------------------------------
    // start taken on the upper input clock edge
    wire tx_begin = transmit_start_bit & ~tx_active_reg & upper_tick;
    wire tx_end = ~transmit_start_bit & tx_active_reg;

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lower_reload_value_reg <= `CNT8_RESET;
            upper_reload_value_reg <= `CNT16_RESET;
            lower_down_counter_reg <= `CNT8_RESET;
            upper_down_counter_reg <= `CNT16_RESET;
            burst_space_toggle_reg <= 1'b0;
            tx_active_reg <= 1'b0;
        end else begin
            // a write beats a reload in the same cycle
            // lower counter: write loads, wrap reloads, else steps
            if (lower_load) begin
                lower_reload_value_reg <= wdata_i[7:0];
                lower_down_counter_reg <= wdata_i[7:0];
            end else if (tx_begin | lower_uf) begin
                lower_down_counter_reg <= lower_reload_value_reg;
            end else if (run & lower_tick) begin
                lower_down_counter_reg <= lower_down_counter_reg - 8'h01;
            end
            // upper counter
            if (casc_wr) begin
                upper_reload_value_reg[7:0] <= wdata_i[15:8];
                upper_down_counter_reg[7:0] <= wdata_i[15:8];
            end else if (upper_wr_ok) begin
                upper_reload_value_reg <= upper_wdata;
                if (upper_direct) begin
                    upper_down_counter_reg <= upper_wdata;
                end
            end else if (tx_begin | upper_uf) begin
                upper_down_counter_reg <= upper_reload_value_reg;
            end else if (upper_tick) begin
                upper_down_counter_reg <= upper_down_counter_reg - 16'h0001;
            end
            // starting in burst puts carrier in the first period
            // burst first, toggling each underflow while sending
            if (tx_begin) begin
                tx_active_reg <= 1'b1;
                burst_space_toggle_reg <= 1'b1;
            end else if (tx_end) begin
                tx_active_reg <= 1'b0;
                burst_space_toggle_reg <= 1'b0;
            end else if (tx_active_reg & upper_uf) begin
                burst_space_toggle_reg <= ~burst_space_toggle_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // read mux and registered outputs
    // ------------------------------------------------------------------
    // counters read live; reload values are write only
    reg [15:0] rd_next;
    always @* begin
        case (addr_i)
            `OFS_CONTROL: rd_next = {8'h00, control_reg};
            `OFS_MODE: rd_next = {8'h00, mode_reg};
            `OFS_FLAGS: rd_next = {8'h00, upper_underflow_flag_reg,
                lower_underflow_flag_reg, 6'h3f};
            `OFS_LOWER: rd_next = cascaded ?
                {upper_down_counter_reg[7:0], lower_down_counter_reg} :
                {8'h00, lower_down_counter_reg};
            // expansion: high byte on low lane, low byte on high lane
            `OFS_UPPER: rd_next = expansion_select ?
                {8'h00, upper_down_counter_reg[7:0]} :
                {upper_down_counter_reg[7:0], upper_down_counter_reg[15:8]};
            `OFS_MSTOP: rd_next = {10'h000, module_stop_reg, 5'h00};
            default: rd_next = 16'h0000;
        endcase
    end

    // requests follow their flag one cycle late
    // outputs all from flops; tone and requests also live in cascade
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= 16'h0000;
            lower_irq_o <= 1'b0;
            upper_irq_o <= 1'b0;
            tone_o <= 1'b0;
            remote_tx_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? rd_next : 16'h0000;
            lower_irq_o <= lower_underflow_flag_reg & control_reg[`CTL_LIE_BIT];
            upper_irq_o <= upper_underflow_flag_reg & control_reg[`CTL_UIE_BIT];
            if (lower_uf8) begin
                tone_o <= ~tone_o;
            end
            // next tone value keeps the carrier in step with tone_o
            // carrier gated by toggle; idle low during space
            remote_tx_o <= tx_active_reg & burst_space_toggle_reg & (tone_o ^ lower_uf8);
        end
    end

endmodule // reload_timer_pair

// ### reload_timer_pair_chk.sv
// Purpose: port-level checker for the reload timer pair
// Assumes: single clock domain, registered outputs, read data one cycle after rd_i
// Notes: attached by bind from the testbench top file
`timescale 1ns/1ps

module reload_timer_pair_chk (
    input wire sys_clk_i,
    input wire resetn_i,
    input wire [2:0] addr_i,
    input wire [15:0] wdata_i,
    input wire [1:0] byte_en_i,
    input wire wr_i,
    input wire rd_i,
    input wire [15:0] rdata_o,
    input wire ext_edge_pin_a_i,
    input wire ext_edge_pin_b_i,
    input wire pin_a_falling_i,
    input wire pin_b_falling_i,
    input wire low_power_i,
    input wire lower_irq_o,
    input wire upper_irq_o,
    input wire tone_o,
    input wire remote_tx_o
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // read data stands one cycle only, otherwise the bus is quiet
    a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_unmapped_zero: assert property (rd_i && addr_i > 3'h5 |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_flag_spare_ones: assert property (rd_i && addr_i == 3'h2 |=> rdata_o[5:0] == 6'h3f)
        else $error("spare flag bits not read as one");
    // fastest tick is two cycles, so tone never flips twice in a row
    a_tone_no_glitch: assert property ($changed(tone_o) |=> $stable(tone_o))
        else $error("tone toggled on consecutive cycles");
    a_lowpower_quiet: assert property (low_power_i [*4] |-> !remote_tx_o)
        else $error("transmit active during low power");
    // interrupt lines drop only after a register write clears flag or enable
    a_lirq_drop: assert property ($fell(lower_irq_o) |->
        ($past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3)))
        else $error("lower request dropped without a write");
    a_uirq_drop: assert property ($fell(upper_irq_o) |->
        ($past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3)))
        else $error("upper request dropped without a write");
    a_outputs_reset: assert property (!$past(resetn_i) |->
        !lower_irq_o && !upper_irq_o && !tone_o && !remote_tx_o)
        else $error("outputs not idle after reset");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    c_tone: cover property ($changed(tone_o));
    c_tx: cover property ($rose(remote_tx_o));
    c_uirq: cover property ($rose(upper_irq_o));
endmodule // reload_timer_pair_chk

// ### tb_top.sv
// Purpose: self-checking bench for the reload timer pair
// Assumes: bench drives the register port directly, pins idle low
// Notes: 8-bit registers sit on the low byte lane
`timescale 1ns/1ps

module tb_top;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic [1:0] byte_en_i = 2'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ext_edge_pin_a_i = 1'b0;
    logic ext_edge_pin_b_i = 1'b0;
    logic pin_a_falling_i = 1'b0;
    logic pin_b_falling_i = 1'b0;
    logic low_power_i = 1'b0;
    wire [15:0] rdata_o;
    wire lower_irq_o, upper_irq_o, tone_o, remote_tx_o;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [15:0] rv;
    int n;

    reload_timer_pair i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .byte_en_i(byte_en_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .ext_edge_pin_a_i(ext_edge_pin_a_i),
        .ext_edge_pin_b_i(ext_edge_pin_b_i), .pin_a_falling_i(pin_a_falling_i),
        .pin_b_falling_i(pin_b_falling_i), .low_power_i(low_power_i),
        .lower_irq_o(lower_irq_o), .upper_irq_o(upper_irq_o), .tone_o(tone_o),
        .remote_tx_o(remote_tx_o));

    // 125 MHz system clock
    always #4 sys_clk_i = ~sys_clk_i;

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe, then an idle cycle so wr_i is never set twice at one edge
    task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
        addr_i <= a;
        wdata_i <= d;
        byte_en_i <= be;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    // read data is only valid in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [15:0] exp, input logic [15:0] m);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
        chk(rv & m, exp & m);
        @(posedge sys_clk_i);
    endtask

    // slow pin edges so the synchroniser always sees them
    task automatic pulse_a(input int k);
        repeat (k) begin
            ext_edge_pin_a_i <= 1'b1;
            repeat (5) @(posedge sys_clk_i);
            ext_edge_pin_a_i <= 1'b0;
            repeat (5) @(posedge sys_clk_i);
        end
    endtask

    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        $display("Error at %0t: watchdog expired", $time);
        n_mismatch++;
        end_of_test;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rd(3'h0, 16'h0008, 16'h00ff);
        rd(3'h1, 16'h0000, 16'h00ff);
        rd(3'h2, 16'h003f, 16'h00ff);
        rd(3'h3, 16'h00ff, 16'h00ff);
        rd(3'h4, 16'h00ff, 16'h00ff);
        rd(3'h5, 16'h0020, 16'h0020);
        wr(3'h7, 16'hffff, 2'h3);
        rd(3'h7, 16'h0000, 16'hffff);
        // stopped: fast clock but no tone activity
        wr(3'h1, 16'h0002, 2'h1);
        repeat (600) @(posedge sys_clk_i);
        chk({15'h0, tone_o}, 16'h0000);
        wr(3'h5, 16'h0000, 2'h3);
        wr(3'h3, 16'h0003, 2'h1);
        // reload 3 on a /2 clock: tone edges 8 cycles apart; first pass aligns
        repeat (2) begin
            rv = {15'h0, tone_o};
            n = 0;
            while (tone_o === rv[0] && n < 100) begin
                @(posedge sys_clk_i);
                n++;
            end
        end
        chk(n[15:0], 16'h0008);
        // pin A event counting, flag clear after read
        wr(3'h1, 16'h0003, 2'h1);
        wr(3'h3, 16'h0001, 2'h1);
        rd(3'h2, 16'h0040, 16'h0040);
        wr(3'h2, 16'h0000, 2'h1);
        rd(3'h2, 16'h0000, 16'h0040);
        pulse_a(2);
        rd(3'h2, 16'h0040, 16'h0040);
        chk({15'h0, lower_irq_o}, 16'h0000);
        wr(3'h0, 16'h000a, 2'h1);
        repeat (3) @(posedge sys_clk_i);
        chk({15'h0, lower_irq_o}, 16'h0001);
        rd(3'h2, 16'h0040, 16'h0040);
        wr(3'h2, 16'h0000, 2'h1);
        repeat (3) @(posedge sys_clk_i);
        chk({15'h0, lower_irq_o}, 16'h0000);
        // upper load on write, then counting lower wraps
        wr(3'h1, 16'h000b, 2'h1);
        wr(3'h4, 16'h0040, 2'h1);
        rd(3'h4, 16'h0040, 16'h00ff);
        wr(3'h0, 16'h000c, 2'h1);
        wr(3'h4, 16'h0002, 2'h1);
        wr(3'h1, 16'h000a, 2'h1);
        n = 0;
        while (upper_irq_o !== 1'b1 && n < 60) begin
            @(posedge sys_clk_i);
            n++;
        end
        chk({15'h0, upper_irq_o}, 16'h0001);
        // cascaded 16-bit: word access only
        wr(3'h1, 16'h002b, 2'h1);
        wr(3'h3, 16'hab12, 2'h3);
        rd(3'h3, 16'hab12, 16'hffff);
        wr(3'h3, 16'h0055, 2'h1);
        rd(3'h3, 16'hab12, 16'hffff);
        // expansion on: swapped lanes, 24-bit chain
        wr(3'h1, 16'h000b, 2'h1);
        wr(3'h0, 16'h0004, 2'h1);
        wr(3'h4, 16'h1234, 2'h3);
        rd(3'h4, 16'h1234, 16'hffff);
        wr(3'h4, 16'h00ff, 2'h1);
        rd(3'h4, 16'h1234, 16'hffff);
        wr(3'h3, 16'h0001, 2'h1);
        wr(3'h4, 16'h0100, 2'h3);
        rd(3'h4, 16'h0100, 16'hffff);
        pulse_a(2);
        rd(3'h4, 16'h0000, 16'hffff);
        // remote transmission with a /2 carrier
        wr(3'h0, 16'h0008, 2'h1);
        wr(3'h3, 16'h0000, 2'h1);
        wr(3'h4, 16'h0008, 2'h1);
        wr(3'h1, 16'h004a, 2'h1);
        wr(3'h1, 16'h00ca, 2'h1);
        repeat (6) @(posedge sys_clk_i);
        rd(3'h1, 16'h0090, 16'h0090);
        wr(3'h4, 16'h0030, 2'h1);
        rd(3'h4, 16'h0000, 16'h00f8);
        n = 0;
        repeat (20) begin
            @(posedge sys_clk_i);
            if (remote_tx_o === 1'b1)
                n++;
        end
        chk({15'h0, n > 0 && n < 20}, 16'h0001);
        // end the frame in space after a request, then restart it
        rd(3'h2, 16'h0080, 16'h0080);
        rd(3'h1, 16'h0080, 16'h0090);
        wr(3'h1, 16'h004a, 2'h1);
        repeat (3) @(posedge sys_clk_i);
        chk({15'h0, remote_tx_o}, 16'h0000);
        wr(3'h1, 16'h00ca, 2'h1);
        low_power_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        low_power_i <= 1'b0;
        rd(3'h1, 16'h0000, 16'h0080);
        repeat (3) @(posedge sys_clk_i);
        chk({15'h0, remote_tx_o}, 16'h0000);
        end_of_test;
    end
endmodule // tb_top

bind reload_timer_pair reload_timer_pair_chk i_chk (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .byte_en_i(byte_en_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_edge_pin_a_i(ext_edge_pin_a_i),
    .ext_edge_pin_b_i(ext_edge_pin_b_i), .pin_a_falling_i(pin_a_falling_i),
    .pin_b_falling_i(pin_b_falling_i), .low_power_i(low_power_i),
    .lower_irq_o(lower_irq_o), .upper_irq_o(upper_irq_o), .tone_o(tone_o),
    .remote_tx_o(remote_tx_o));
